// [rtl/image_check_pkg.sv]
// Constants for the configuration image checker
// What this block does
// - Primary high checksum is XOR of words 00-0E, except 08, 09, 0D.
// - Primary low checksum is XOR of words 08, 09 and 0D only.
// - Secondary high checksum covers words 10-12 and 20-3F.
// - Secondary low checksum covers words 13 through 16.
// - Date holds year 0-99, month 1-12, day 1-31.
// - Date word: year bits 15:9, month 8:5, day 4:0.
// - Software info bits 5:4 give the environment hint.
// - Capabilities bit 0 plug-and-play, bit 7 CRC pass, bit 13 power commands.
// - Capability reserved bits zero, bit 1 one, bits 2-6, 8-12 and 14-15 zero.
// - Secondary info bit 14 one enables automatic power control.
// - Secondary info bit 4 marks boot ROM fitted, size field valid.
// - Secondary info bits 3:0 carry the card revision level.
// - Words 18-3F are delivered as resource data when read.
// - First nine plug-and-play bytes are shifted out for isolation.
// - Word 1C upper byte is fixed at 8C.
package image_check_pkg;
	localparam logic [5:0] OFF_DATE = 6'h04;
	localparam logic [5:0] OFF_ADDR_CFG = 6'h08;
	localparam logic [5:0] OFF_RES_CFG = 6'h09;
	localparam logic [5:0] OFF_SW_INFO = 6'h0D;
	localparam logic [5:0] OFF_COMPAT = 6'h0E;
	localparam logic [5:0] OFF_CHECKSUM = 6'h0F;
	localparam logic [5:0] OFF_CAPS = 6'h10;
	localparam logic [5:0] OFF_ICFG0 = 6'h12;
	localparam logic [5:0] OFF_CFG_FIRST = 6'h13;
	localparam logic [5:0] OFF_CFG_LAST = 6'h16;
	localparam logic [5:0] OFF_SEC_SW = 6'h14;
	localparam logic [5:0] OFF_SEC_CHECKSUM = 6'h17;
	localparam logic [5:0] OFF_PNP_FIRST = 6'h18;
	localparam logic [5:0] OFF_PNP_FIXED = 6'h1C;
	localparam logic [5:0] OFF_VITAL_TAIL = 6'h20;
	localparam logic [5:0] OFF_LAST = 6'h3F;
	localparam logic [7:0] PNP_FIXED_HIGH = 8'h8C;
	localparam int PNP_WORDS = 40;
	localparam logic [6:0] PNP_BYTES = 7'h50;
	localparam logic [6:0] ISO_BITS = 7'h48;
	// Date fields
	localparam int YEAR_MSB = 15;
	localparam int YEAR_LSB = 9;
	localparam int MONTH_MSB = 8;
	localparam int MONTH_LSB = 5;
	localparam int DAY_MSB = 4;
	localparam int DAY_LSB = 0;
	localparam logic [6:0] YEAR_MAX = 7'h63;
	localparam logic [3:0] MONTH_MAX = 4'hC;
	localparam logic [4:0] DAY_MAX = 5'h1F;
	// Software information fields
	localparam int LINK_DIS_BIT = 14;
	localparam int IRQ_OFF_MSB = 13;
	localparam int IRQ_OFF_LSB = 8;
	localparam int ENV_MSB = 5;
	localparam int ENV_LSB = 4;
	// Compatibility fields
	localparam int FAIL_MSB = 15;
	localparam int FAIL_LSB = 8;
	localparam int WARN_MSB = 7;
	localparam int WARN_LSB = 0;
	// Capabilities fields
	localparam int CAP_PNP_BIT = 0;
	localparam int CAP_CRC_BIT = 7;
	localparam int CAP_POWER_BIT = 13;
	localparam logic [15:0] CAP_FIXED_MASK = 16'hDF7E;
	localparam logic [15:0] CAP_FIXED_VALUE = 16'h0002;
	// Secondary software information fields
	localparam int AUTO_POWER_BIT = 14;
	localparam int BOOT_ROM_BIT = 4;
	localparam int REV_MSB = 3;
	localparam int REV_LSB = 0;
	// Mismatch flag positions
	localparam int MIS_PRIM_HI = 0;
	localparam int MIS_PRIM_LO = 1;
	localparam int MIS_VITAL = 2;
	localparam int MIS_CFG = 3;
endpackage : image_check_pkg

// [rtl/pnp_word_store.sv]
// Word memory for the plug-and-play area, registered read
`timescale 1ns/1ps
module pnp_word_store #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 40,
	parameter int AW = 6
) (
	input wire logic core_clk,
	input wire logic ce,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic rd_en,
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [WIDTH-1:0] rd_data_q;

	if (DEPTH > (1 << AW) || DEPTH < 1) begin : g_bad_depth
		$error("pnp_word_store: DEPTH does not fit AW");
	end

	always_ff @(posedge core_clk) begin
		if (ce && wr_en && int'(wr_addr) < DEPTH) begin
			mem[wr_addr] <= wr_data;
		end
		if (ce && rd_en) begin
			rd_data_q <= (int'(rd_addr) < DEPTH) ? mem[rd_addr] : '0;
		end
	end

	assign rd_data = rd_data_q;
endmodule : pnp_word_store

// [rtl/config_eeprom_image_checker.sv]
// Configuration image decode, checksum check and plug-and-play delivery
`timescale 1ns/1ps
module config_eeprom_image_checker
	import image_check_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic image_start,
	input wire logic word_valid,
	input wire logic [5:0] word_offset,
	input wire logic [15:0] word_data,
	input wire logic res_rd_req,
	input wire logic res_rewind,
	input wire logic iso_bit_req,
	input wire logic iso_rewind,
	output logic [3:0] checksum_mismatch,
	output logic check_done,
	output logic [6:0] date_year,
	output logic [3:0] date_month,
	output logic [4:0] date_day,
	output logic date_ok,
	output logic link_pulse_disable_bit,
	output logic [6:0] irq_off_units,
	output logic [1:0] env_hint,
	output logic [7:0] fail_level,
	output logic [7:0] warn_level,
	output logic cap_pnp,
	output logic cap_crc_pass,
	output logic cap_power_cmds,
	output logic cap_fixed_error,
	output logic auto_power_select,
	output logic boot_rom_size_valid,
	output logic [3:0] card_revision,
	output logic pnp_fixed_error,
	output logic [7:0] res_data,
	output logic res_valid,
	output logic iso_bit,
	output logic iso_valid,
	output logic read_busy
);
	typedef enum logic {RD_IDLE, RD_FETCH} rd_state_type;

	typedef struct packed {
		logic [7:0] acc_prim_hi, acc_prim_lo, acc_vital, acc_cfg;
		logic [15:0] stored_prim, stored_sec;
		logic [3:0] mismatch;
		logic done;
		logic [6:0] year;
		logic [3:0] month;
		logic [4:0] day;
		logic date_ok, link_dis;
		logic [6:0] irq_units;
		logic [1:0] env;
		logic [7:0] fail_lvl, warn_lvl;
		logic cap_pnp, cap_crc, cap_power, cap_err, auto_power, boot_rom;
		logic [3:0] revision;
		logic pnp_err;
		rd_state_type rd_state;
		logic rd_is_iso, iso_pend;
		logic [6:0] res_ptr, iso_ptr;
		logic [7:0] res_byte;
		logic res_valid, iso_bit, iso_valid, busy;
	} state_type;

	state_type state_q;
	state_type state_d;
	logic mem_wr;
	logic mem_rd;
	logic [5:0] mem_rd_addr;
	logic [15:0] mem_rd_data;
	logic [7:0] fold;
	logic [7:0] picked;

	// ==========================================================
	// Plug-and-play word store
	assign mem_wr = word_valid && !image_start && word_offset >= OFF_PNP_FIRST;

	pnp_word_store #(.WIDTH(16), .DEPTH(PNP_WORDS), .AW(6)) u_store (
		.core_clk(core_clk),
		.ce(ce),
		.wr_en(mem_wr),
		.wr_addr(word_offset - OFF_PNP_FIRST),
		.wr_data(word_data),
		.rd_en(mem_rd),
		.rd_addr(mem_rd_addr),
		.rd_data(mem_rd_data)
	);

	// ==========================================================
	// Next state
	always_comb begin
		state_d = state_q;
		fold = word_data[15:8] ^ word_data[7:0];
		mem_rd = 1'b0;
		mem_rd_addr = '0;
		picked = '0;
		state_d.res_valid = 1'b0;
		state_d.iso_valid = 1'b0;
		if (iso_bit_req) begin
			state_d.iso_pend = 1'b1;
		end
		if (image_start) begin
			// Fresh image read: sums and flags restart
			{state_d.acc_prim_hi, state_d.acc_prim_lo, state_d.acc_vital,
				state_d.acc_cfg} = '0;
			state_d.mismatch = '0;
			state_d.done = 1'b0;
		end else if (word_valid) begin
			if (word_offset <= OFF_COMPAT) begin
				if (word_offset == OFF_ADDR_CFG || word_offset == OFF_RES_CFG ||
						word_offset == OFF_SW_INFO) begin
					state_d.acc_prim_lo = state_q.acc_prim_lo ^ fold;
				end else begin
					state_d.acc_prim_hi = state_q.acc_prim_hi ^ fold;
				end
			end
			if ((word_offset >= OFF_CAPS && word_offset <= OFF_ICFG0) ||
					word_offset >= OFF_VITAL_TAIL) begin
				state_d.acc_vital = state_q.acc_vital ^ fold;
			end
			if (word_offset >= OFF_CFG_FIRST && word_offset <= OFF_CFG_LAST) begin
				state_d.acc_cfg = state_q.acc_cfg ^ fold;
			end
			unique case (word_offset)
				OFF_DATE: begin
					state_d.year = word_data[YEAR_MSB:YEAR_LSB];
					state_d.month = word_data[MONTH_MSB:MONTH_LSB];
					state_d.day = word_data[DAY_MSB:DAY_LSB];
					state_d.date_ok = word_data[YEAR_MSB:YEAR_LSB] <= YEAR_MAX &&
						word_data[MONTH_MSB:MONTH_LSB] inside {[4'h1:MONTH_MAX]} &&
						word_data[DAY_MSB:DAY_LSB] inside {[5'h01:DAY_MAX]};
				end
				OFF_SW_INFO: begin
					state_d.link_dis = word_data[LINK_DIS_BIT];
					state_d.irq_units = {1'b0, word_data[IRQ_OFF_MSB:IRQ_OFF_LSB]} + 7'h01;
					state_d.env = word_data[ENV_MSB:ENV_LSB];
				end
				OFF_COMPAT: begin
					state_d.fail_lvl = word_data[FAIL_MSB:FAIL_LSB];
					state_d.warn_lvl = word_data[WARN_MSB:WARN_LSB];
				end
				OFF_CHECKSUM: state_d.stored_prim = word_data;
				OFF_CAPS: begin
					state_d.cap_pnp = word_data[CAP_PNP_BIT];
					state_d.cap_crc = word_data[CAP_CRC_BIT];
					state_d.cap_power = word_data[CAP_POWER_BIT];
					state_d.cap_err = (word_data & CAP_FIXED_MASK) != CAP_FIXED_VALUE;
				end
				OFF_SEC_SW: begin
					state_d.auto_power = word_data[AUTO_POWER_BIT];
					state_d.boot_rom = word_data[BOOT_ROM_BIT];
					state_d.revision = word_data[REV_MSB:REV_LSB];
				end
				OFF_SEC_CHECKSUM: state_d.stored_sec = word_data;
				OFF_PNP_FIXED: state_d.pnp_err = word_data[15:8] != PNP_FIXED_HIGH;
				OFF_LAST: begin
					// Last covered word: compare with the final sums, flags only set here
					state_d.done = 1'b1;
					state_d.mismatch[MIS_PRIM_HI] = state_q.mismatch[MIS_PRIM_HI] |
						(state_q.acc_prim_hi != state_q.stored_prim[15:8]);
					state_d.mismatch[MIS_PRIM_LO] = state_q.mismatch[MIS_PRIM_LO] |
						(state_q.acc_prim_lo != state_q.stored_prim[7:0]);
					state_d.mismatch[MIS_VITAL] = state_q.mismatch[MIS_VITAL] |
						((state_q.acc_vital ^ fold) != state_q.stored_sec[15:8]);
					state_d.mismatch[MIS_CFG] = state_q.mismatch[MIS_CFG] |
						(state_q.acc_cfg != state_q.stored_sec[7:0]);
				end
				default: ;
			endcase
		end
		// Resource and isolation readout share one store port
		if (res_rewind) begin
			state_d.res_ptr = '0;
		end
		if (iso_rewind) begin
			state_d.iso_ptr = '0;
		end
		unique case (state_q.rd_state)
			RD_IDLE: begin
				if (res_rd_req) begin
					mem_rd = 1'b1;
					mem_rd_addr = state_q.res_ptr[6:1];
					state_d.rd_is_iso = 1'b0;
					state_d.rd_state = RD_FETCH;
					state_d.busy = 1'b1;
				end else if (state_q.iso_pend || iso_bit_req) begin
					mem_rd = 1'b1;
					mem_rd_addr = {3'b000, state_q.iso_ptr[6:4]};
					state_d.rd_is_iso = 1'b1;
					state_d.iso_pend = 1'b0;
					state_d.rd_state = RD_FETCH;
					state_d.busy = 1'b1;
				end
			end
			RD_FETCH: begin
				state_d.rd_state = RD_IDLE;
				state_d.busy = 1'b0;
				if (state_q.rd_is_iso) begin
					picked = state_q.iso_ptr[3] ? mem_rd_data[15:8] : mem_rd_data[7:0];
					state_d.iso_bit = picked[state_q.iso_ptr[2:0]];
					state_d.iso_valid = 1'b1;
					if (!iso_rewind) begin
						state_d.iso_ptr = (state_q.iso_ptr == ISO_BITS - 7'h01) ? '0 :
							state_q.iso_ptr + 7'h01;
					end
				end else begin
					state_d.res_byte = state_q.res_ptr[0] ? mem_rd_data[15:8] :
						mem_rd_data[7:0];
					state_d.res_valid = 1'b1;
					if (!res_rewind) begin
						state_d.res_ptr = (state_q.res_ptr == PNP_BYTES - 7'h01) ? '0 :
							state_q.res_ptr + 7'h01;
					end
				end
			end
		endcase
	end

	// ==========================================================
	// State register
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_q <= '0;
		end else if (ce) begin
			state_q <= state_d;
		end
	end

	assign {checksum_mismatch, check_done, date_year, date_month, date_day, date_ok,
		link_pulse_disable_bit, irq_off_units, env_hint, fail_level, warn_level} =
		{state_q.mismatch, state_q.done, state_q.year, state_q.month, state_q.day,
		state_q.date_ok, state_q.link_dis, state_q.irq_units, state_q.env, state_q.fail_lvl,
		state_q.warn_lvl};
	assign {cap_pnp, cap_crc_pass, cap_power_cmds, cap_fixed_error, auto_power_select,
		boot_rom_size_valid, card_revision, pnp_fixed_error} = {state_q.cap_pnp,
		state_q.cap_crc, state_q.cap_power, state_q.cap_err, state_q.auto_power,
		state_q.boot_rom, state_q.revision, state_q.pnp_err};
	assign {res_data, res_valid, iso_bit, iso_valid, read_busy} = {state_q.res_byte,
		state_q.res_valid, state_q.iso_bit, state_q.iso_valid, state_q.busy};

	// ==========================================================
	// Checks
	property p_res_answer;
		@(posedge core_clk) disable iff (reset || !ce)
		res_rd_req && !state_q.busy ##1 1'b1 |=> res_valid && !read_busy;
	endproperty
	a_res_answer: assert property (p_res_answer) else $error("resource byte late");
	property p_iso_answer;
		@(posedge core_clk) disable iff (reset || !ce)
		iso_bit_req && !res_rd_req && !state_q.busy |-> ##2 iso_valid && !res_valid;
	endproperty
	a_iso_answer: assert property (p_iso_answer) else $error("isolation bit late");
	property p_flag_cause;
		@(posedge core_clk) disable iff (reset || !ce)
		$rose(checksum_mismatch[MIS_PRIM_HI]) |->
			$past(word_valid && word_offset == OFF_LAST && !image_start);
	endproperty
	a_flag_cause: assert property (p_flag_cause) else $error("mismatch set early");
	property p_restart;
		@(posedge core_clk) disable iff (reset || !ce)
		image_start |=> checksum_mismatch == 4'h0 && !check_done;
	endproperty
	a_restart: assert property (p_restart) else $error("image restart left flags");
	property p_date_fields;
		@(posedge core_clk) disable iff (reset || !ce)
		word_valid && !image_start && word_offset == OFF_DATE |=>
			date_year == $past(word_data[15:9]) && date_day == $past(word_data[4:0]);
	endproperty
	a_date_fields: assert property (p_date_fields) else $error("date split wrong");
	property p_date_range;
		@(posedge core_clk) disable iff (reset || !ce)
		date_ok |-> date_month >= 4'h1 && date_month <= 4'hC && date_year <= 7'h63;
	endproperty
	a_date_range: assert property (p_date_range) else $error("date range wrong");
	property p_caps;
		@(posedge core_clk) disable iff (reset || !ce)
		word_valid && !image_start && word_offset == OFF_CAPS |=>
			cap_pnp == $past(word_data[0]) && cap_power_cmds == $past(word_data[13]);
	endproperty
	a_caps: assert property (p_caps) else $error("capability bits wrong");
	property p_env;
		@(posedge core_clk) disable iff (reset || !ce)
		word_valid && !image_start && word_offset == OFF_SW_INFO |=>
			env_hint == $past(word_data[5:4]);
	endproperty
	a_env: assert property (p_env) else $error("environment hint wrong");
	property p_auto_power;
		@(posedge core_clk) disable iff (reset || !ce)
		word_valid && !image_start && word_offset == OFF_SEC_SW |=>
			auto_power_select == $past(word_data[14]) && card_revision == $past(word_data[3:0]);
	endproperty
	a_auto_power: assert property (p_auto_power) else $error("secondary info wrong");
endmodule : config_eeprom_image_checker

// [tb/eeprom_image_source.sv]
// Far-side model: configuration word source and host driver reactions
`timescale 1ns/1ps
module eeprom_image_source
	import image_check_pkg::*;
#(
	parameter logic [7:0] DRIVER_LEVEL = 8'h01
) (
	input wire logic core_clk,
	output logic image_start,
	output logic word_valid,
	output logic [5:0] word_offset,
	output logic [15:0] word_data,
	input wire logic link_pulse_disable_bit,
	input wire logic [6:0] irq_off_units,
	input wire logic [7:0] fail_level,
	input wire logic [7:0] warn_level,
	output logic media_link_bit,
	output logic [10:0] irq_limit_us,
	output logic install_refused,
	output logic upgrade_advised
);
	logic [15:0] mem [64];

	initial begin
		image_start = 1'b0;
		word_valid = 1'b0;
		word_offset = 6'h00;
		word_data = 16'hFFFF;
	end

	// ==========================================
	// Driver reactions to the decoded fields
	assign media_link_bit = ~link_pulse_disable_bit;
	assign irq_limit_us = 11'(irq_off_units) * 11'h019;
	assign install_refused = fail_level > DRIVER_LEVEL;
	assign upgrade_advised = warn_level > DRIVER_LEVEL;

	// ==========================================
	// Stored checksum words
	task automatic fill_sums();
		logic [7:0] ph, pl, vh, cl, x;
		{ph, pl, vh, cl} = 32'h0000_0000;
		for (int i = 0; i < 64; i++) begin
			x = mem[i][15:8] ^ mem[i][7:0];
			if (i <= 14 && i != 8 && i != 9 && i != 13) ph ^= x;
			if (i == 8 || i == 9 || i == 13) pl ^= x;
			if ((i >= 16 && i <= 18) || i >= 32) vh ^= x;
			if (i >= 19 && i <= 22) cl ^= x;
		end
		mem[15] = {ph, pl};
		mem[23] = {vh, cl};
	endtask : fill_sums

	// ==========================================
	// Word streaming; released data lines show the inverse
	task automatic send_image();
		@(posedge core_clk);
		image_start <= 1'b1;
		@(posedge core_clk);
		image_start <= 1'b0;
		word_valid <= 1'b1;
		for (int i = 0; i < 64; i++) begin
			word_offset <= 6'(i);
			word_data <= mem[i];
			@(posedge core_clk);
		end
		word_valid <= 1'b0;
		word_data <= ~mem[63];
	endtask : send_image

	task automatic send_word(input logic [5:0] off, input logic [15:0] data);
		@(posedge core_clk);
		word_valid <= 1'b1;
		word_offset <= off;
		word_data <= data;
		mem[off] = data;
		@(posedge core_clk);
		word_valid <= 1'b0;
		word_data <= ~data;
	endtask : send_word
endmodule : eeprom_image_source

// [tb/test_config_eeprom_image_checker.sv]
// Self-checking bench for the configuration image checker
`timescale 1ns/1ps
module test_config_eeprom_image_checker
	import image_check_pkg::*;
;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic res_rd_req = 1'b0;
	logic res_rewind = 1'b0;
	logic iso_bit_req = 1'b0;
	logic iso_rewind = 1'b0;
	logic ce = 1'b1;
	logic image_start, word_valid, check_done, date_ok, link_pulse_disable_bit;
	logic [5:0] word_offset;
	logic [15:0] word_data;
	logic [3:0] checksum_mismatch, card_revision, date_month;
	logic [6:0] date_year, irq_off_units;
	logic [4:0] date_day;
	logic [7:0] fail_level, warn_level, res_data;
	logic [1:0] env_hint;
	logic cap_pnp, cap_crc_pass, cap_power_cmds, cap_fixed_error, auto_power_select;
	logic boot_rom_size_valid, pnp_fixed_error, res_valid, iso_bit, iso_valid, read_busy;
	logic media_link_bit, install_refused, upgrade_advised;
	logic [10:0] irq_limit_us;
	int num_errors = 0;
	int comparisons = 0;

	always #10 core_clk = ~core_clk;

	config_eeprom_image_checker u_config_eeprom_image_checker (.core_clk, .reset, .ce,
		.image_start, .word_valid, .word_offset, .word_data, .res_rd_req, .res_rewind,
		.iso_bit_req, .iso_rewind, .checksum_mismatch, .check_done, .date_year, .date_month,
		.date_day, .date_ok, .link_pulse_disable_bit, .irq_off_units, .env_hint, .fail_level,
		.warn_level, .cap_pnp, .cap_crc_pass, .cap_power_cmds, .cap_fixed_error,
		.auto_power_select, .boot_rom_size_valid, .card_revision, .pnp_fixed_error,
		.res_data, .res_valid, .iso_bit, .iso_valid, .read_busy);

	eeprom_image_source u_eeprom_image_source (.core_clk, .image_start, .word_valid,
		.word_offset, .word_data, .link_pulse_disable_bit, .irq_off_units, .fail_level,
		.warn_level, .media_link_bit, .irq_limit_us, .install_refused, .upgrade_advised);

	// ==========================================
	// Shared helpers
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	task automatic give_verdict();
		if (num_errors == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : give_verdict

	task automatic put(input logic [5:0] off, input logic [15:0] w);
		u_eeprom_image_source.send_word(off, w);
		@(posedge core_clk);
		#1;
	endtask : put

	task automatic image();
		u_eeprom_image_source.send_image();
		repeat (2) @(posedge core_clk);
		#1;
		check(check_done, 1, "done");
	endtask : image

	// ==========================================
	// Scenarios
	task automatic t_clean();
		for (int i = 0; i < 64; i++) u_eeprom_image_source.mem[i] = 16'hA5C3 ^ 16'(i * 291);
		u_eeprom_image_source.mem[4] = 16'hC79F;
		u_eeprom_image_source.mem[16] = 16'h2082;
		u_eeprom_image_source.mem[20] = 16'h4015;
		u_eeprom_image_source.mem[28] = 16'h8C33;
		u_eeprom_image_source.fill_sums();
		image();
		check(checksum_mismatch, 0, "clean sums");
		check({date_year, date_month, date_day, date_ok}, {16'hC79F, 1'b1}, "date");
		check({cap_pnp, cap_crc_pass, cap_power_cmds, cap_fixed_error}, 4'h6, "caps");
		check({auto_power_select, boot_rom_size_valid, card_revision}, 6'h35, "sec");
		check(pnp_fixed_error, 0, "fixed byte");
	endtask : t_clean

	task automatic t_corrupt();
		logic [5:0] spot [4] = '{6'h00, 6'h08, 6'h20, 6'h13};
		for (int k = 0; k < 4; k++) begin
			u_eeprom_image_source.mem[spot[k]] ^= 16'h0100;
			image();
			check(checksum_mismatch, 32'h1 << k, "mismatch");
			u_eeprom_image_source.mem[spot[k]] ^= 16'h0100;
		end
		@(posedge core_clk);
		reset <= 1'b1;
		@(posedge core_clk);
		reset <= 1'b0;
		#1;
		check({checksum_mismatch, check_done}, 0, "reset clears");
		image();
		check(checksum_mismatch, 0, "recomputed");
	endtask : t_corrupt

	task automatic t_fields();
		logic [15:0] dw [6] = '{16'hC79F, 16'h0BA1, 16'h0A01, 16'h0A20, 16'hC821, 16'h0021};
		logic [15:0] cw [4] = '{16'h2082, 16'h0081, 16'h2482, 16'hA083};
		logic [15:0] w;
		for (int i = 0; i < 6; i++) begin
			w = dw[i];
			put(6'h04, w);
			check({date_year, date_month, date_day}, w, "date fields");
			check(date_ok, w[15:9] <= 7'h63 && w[8:5] != 4'h0 && w[8:5] <= 4'hC
				&& w[4:0] != 5'h00, "date range");
		end
		// Clock enable low: a word must leave the fields untouched
		ce <= 1'b0;
		put(6'h04, 16'hC79F);
		check({date_year, date_month, date_day}, 16'h0021, "frozen");
		ce <= 1'b1;
		for (int e = 0; e < 4; e++) begin
			w = {1'b0, e[0], 6'(e * 21), 2'b00, e[1:0], 4'h0};
			put(6'h0D, w);
			check({link_pulse_disable_bit, irq_off_units, env_hint},
				{e[0], 7'(e * 21 + 1), e[1:0]}, "sw info");
			check({media_link_bit, irq_limit_us}, {~e[0], 11'((e * 21 + 1) * 25)}, "driver");
			w = e[0] ? 16'h0201 : 16'h0102;
			put(6'h0E, w);
			check({fail_level, warn_level, install_refused, upgrade_advised},
				{w, e[0], ~e[0]}, "compat");
		end
		for (int i = 0; i < 4; i++) begin
			w = cw[i];
			put(6'h10, w);
			check({cap_pnp, cap_crc_pass, cap_power_cmds, cap_fixed_error},
				{w[0], w[7], w[13], (w & 16'hDF7E) != 16'h0002}, "caps");
		end
		put(6'h14, 16'h0001);
		check({auto_power_select, boot_rom_size_valid, card_revision}, 6'h01, "sec");
		put(6'h1C, 16'h8D33);
		check(pnp_fixed_error, 1, "fixed byte bad");
		put(6'h1C, 16'h8C33);
		check(pnp_fixed_error, 0, "fixed byte good");
	endtask : t_fields

	task automatic t_resource();
		logic [15:0] w;
		@(posedge core_clk);
		res_rewind <= 1'b1;
		@(posedge core_clk);
		res_rewind <= 1'b0;
		for (int k = 0; k < 81; k++) begin
			w = u_eeprom_image_source.mem[24 + (k % 80) / 2];
			@(posedge core_clk);
			res_rd_req <= 1'b1;
			@(posedge core_clk);
			res_rd_req <= 1'b0;
			#1;
			check(read_busy, 1, "busy");
			@(posedge core_clk);
			#1;
			check({res_valid, read_busy, res_data}, {2'b10, k[0] ? w[15:8] : w[7:0]},
				"res");
		end
	endtask : t_resource

	task automatic t_isolation();
		logic [15:0] w;
		int b;
		@(posedge core_clk);
		iso_rewind <= 1'b1;
		@(posedge core_clk);
		iso_rewind <= 1'b0;
		for (int k = 0; k < 73; k++) begin
			b = (k % 72) / 8;
			w = u_eeprom_image_source.mem[24 + b / 2];
			@(posedge core_clk);
			iso_bit_req <= 1'b1;
			@(posedge core_clk);
			iso_bit_req <= 1'b0;
			@(posedge core_clk);
			#1;
			check({iso_valid, iso_bit}, {1'b1, w[(b % 2) * 8 + k % 8]}, "iso");
		end
		// Tie: resource first, isolation request held as pending
		w = u_eeprom_image_source.mem[24];
		@(posedge core_clk);
		res_rd_req <= 1'b1;
		iso_bit_req <= 1'b1;
		@(posedge core_clk);
		res_rd_req <= 1'b0;
		iso_bit_req <= 1'b0;
		@(posedge core_clk);
		#1;
		check({res_valid, iso_valid, res_data}, {2'b10, w[15:8]}, "res first");
		repeat (2) @(posedge core_clk);
		#1;
		check({iso_valid, iso_bit}, {1'b1, w[1]}, "iso pending");
	endtask : t_isolation

	// ==========================================
	// Main sequence and watchdog
	initial begin
		repeat (10) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		#1;
		check({checksum_mismatch, check_done, res_valid, read_busy}, 0, "reset");
		t_clean();
		t_corrupt();
		t_fields();
		t_resource();
		t_isolation();
		give_verdict();
	end

	initial begin
		repeat (20000) @(posedge core_clk);
		num_errors++;
		$display("CHECK FAILED at %0t: watchdog", $time);
		give_verdict();
	end
endmodule : test_config_eeprom_image_checker
